// File: inc/por_seq_pkg.sv
// package with phase timing, filter times and grouped signal types for the supply monitor and reset sequencer
// What this block does
// R1: four phases: 1032, 1180, 688, 617 oscillator cycles
// R2: release CPU reset after last phase, fetch zero
// R3: power-good low while monitor reports supply low
// R4: low power-good isolates core and I/O control
// R5: I/O undervoltage asserts internal power-on reset
// R6: core out of range: outputs hi-Z, reset
// R7: monitoring off during any low-power mode
// R8: reset pin filter: ignore <500ns, reset >2000ns
// R9: supply glitches up to 250ns-1us rejected
// R10: supervisor holds reset pin while supplies bad
// R11: any reset drives warm reset pin low
// R12: new power-on reset restarts phases, holds CPU
package por_seq_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned OSC_START_CYC = 1032;
   localparam int unsigned FUSE_LOAD_CYC = 1180;
   localparam int unsigned PUMP_UP_CYC = 688;
   localparam int unsigned BANK_UP_CYC = 617;
   // the pin filter acts between its least and longest time; the chosen point is the least
   localparam int unsigned PIN_FILT_MIN_NS = 500;
   localparam int unsigned PIN_FILT_MAX_NS = 2000;
   localparam int unsigned PIN_FILT_CYC = (PIN_FILT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned SUP_GLITCH_MIN_NS = 250;
   localparam int unsigned SUP_GLITCH_MAX_NS = 1000;
   localparam int unsigned SUP_FILT_CYC = (SUP_GLITCH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W = 11;
   localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      PH_RESET,
      PH_OSC,
      PH_FUSE,
      PH_PUMP,
      PH_BANK,
      PH_RUN
   } phase_t;

   typedef struct packed {
      logic core_low;
      logic core_high;
      logic io_low;
   } supply_flags_t;

   typedef struct packed {
      logic core_power_good;
      logic io_power_good;
      logic core_isolate;
      logic io_isolate;
      logic outputs_hiz;
   } power_status_t;
endpackage

// File: rtl/debounce_level.sv
// synchroniser and persistence filter for one asynchronous level input
module debounce_level #(
   parameter int unsigned FILT_CYC = 63,
   parameter bit RESET_VAL = 1'b0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // level in and filtered out
   input wire logic i_level,
   output logic o_level
);
   localparam int unsigned W = $clog2(FILT_CYC + 1);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic [W-1:0] cnt_q;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
      end else begin
         s1_q <= i_level;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts only while stages two and three agree and differ from the output
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= '0;
         o_level <= RESET_VAL;
      end else if (s2_q != s3_q || s3_q == o_level) begin
         cnt_q <= '0;
      end else if (cnt_q == W'(FILT_CYC - 1)) begin
         cnt_q <= '0;
         o_level <= s3_q;
      end else begin
         cnt_q <= cnt_q + W'(1);
      end
   end
endmodule

// File: rtl/supply_monitor_por_sequencer.sv
// power-on reset with supply monitoring and power-up phase sequencing
module supply_monitor_por_sequencer #(
   parameter int unsigned OSC_START_CYC = por_seq_pkg::OSC_START_CYC,
   parameter int unsigned FUSE_LOAD_CYC = por_seq_pkg::FUSE_LOAD_CYC,
   parameter int unsigned PUMP_UP_CYC = por_seq_pkg::PUMP_UP_CYC,
   parameter int unsigned BANK_UP_CYC = por_seq_pkg::BANK_UP_CYC
) (
   // oscillator clock and raw reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // external pin and analog comparator flags
   input wire logic i_power_on_reset_n,
   input wire por_seq_pkg::supply_flags_t i_supply_flags,
   input wire logic i_low_power_mode,
   // warm reset pin, open drain
   input wire logic i_warm_reset_n,
   output logic o_warm_reset_n,
   output logic o_warm_reset_n_oe,
   // status and sequencing outputs
   output por_seq_pkg::power_status_t o_status,
   output logic o_por_n,
   output logic o_warm_req,
   output logic o_cpu_reset_n,
   output logic [31:0] o_boot_addr,
   output por_seq_pkg::phase_t o_phase
);
   logic pin_n_f;
   logic core_low_f;
   logic core_high_f;
   logic io_low_f;
   logic warm_pin_f;
   logic mon_en;
   logic core_bad;
   logic io_bad;
   logic por_req;
   logic por_n_q;
   por_seq_pkg::phase_t phase_q;
   logic [por_seq_pkg::CNT_W-1:0] cnt_q;

   // ****************************************
   // input filters
   // ****************************************
   debounce_level #(.FILT_CYC(por_seq_pkg::PIN_FILT_CYC), .RESET_VAL(1'b0)) u_pin_filt (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_level(i_power_on_reset_n), .o_level(pin_n_f)); // see R8
   debounce_level #(.FILT_CYC(por_seq_pkg::SUP_FILT_CYC), .RESET_VAL(1'b1)) u_core_low (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_level(i_supply_flags.core_low), .o_level(core_low_f)); // see R9
   debounce_level #(.FILT_CYC(por_seq_pkg::SUP_FILT_CYC), .RESET_VAL(1'b0)) u_core_high (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_level(i_supply_flags.core_high), .o_level(core_high_f)); // see R9
   debounce_level #(.FILT_CYC(por_seq_pkg::SUP_FILT_CYC), .RESET_VAL(1'b1)) u_io_low (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_level(i_supply_flags.io_low), .o_level(io_low_f)); // see R9
   debounce_level #(.FILT_CYC(por_seq_pkg::PIN_FILT_CYC), .RESET_VAL(1'b1)) u_warm_filt (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_level(i_warm_reset_n), .o_level(warm_pin_f));

   // ****************************************
   // monitor decisions
   // ****************************************
   assign mon_en = !i_low_power_mode; // see R7
   assign core_bad = mon_en && (core_low_f || core_high_f);
   assign io_bad = mon_en && io_low_f;
   // pin filter relies on the supervisor holding the pin while supplies are bad, see R10
   assign por_req = !pin_n_f || io_bad || core_bad; // see R5

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         por_n_q <= 1'b0;
      end else begin
         por_n_q <= !por_req; // see R5
      end
   end

   // power-good and isolation follow the monitor directly
   always_comb begin
      o_status.core_power_good = !(mon_en && core_low_f); // see R3
      o_status.io_power_good = !io_bad; // see R3
      o_status.core_isolate = !o_status.core_power_good || !o_status.io_power_good; // see R4
      o_status.io_isolate = !o_status.core_power_good || !o_status.io_power_good; // see R4
      // raw flag path is unclocked so the pins float at once; gated by monitor enable
      o_status.outputs_hiz = mon_en && (i_supply_flags.core_low || i_supply_flags.core_high || core_bad); // see R6
   end

   // ****************************************
   // phase sequencer
   // ****************************************
   function automatic logic [por_seq_pkg::CNT_W-1:0] phase_len(input por_seq_pkg::phase_t ph);
      case (ph)
         por_seq_pkg::PH_OSC: phase_len = por_seq_pkg::CNT_W'(OSC_START_CYC - 1);
         por_seq_pkg::PH_FUSE: phase_len = por_seq_pkg::CNT_W'(FUSE_LOAD_CYC - 1);
         por_seq_pkg::PH_PUMP: phase_len = por_seq_pkg::CNT_W'(PUMP_UP_CYC - 1);
         default: phase_len = por_seq_pkg::CNT_W'(BANK_UP_CYC - 1);
      endcase
   endfunction

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase_q <= por_seq_pkg::PH_RESET;
         cnt_q <= '0;
      end else if (!por_n_q) begin
         phase_q <= por_seq_pkg::PH_RESET; // see R12
         cnt_q <= '0;
      end else begin
         case (phase_q)
            por_seq_pkg::PH_RESET: begin
               phase_q <= por_seq_pkg::PH_OSC;
               cnt_q <= '0;
            end
            por_seq_pkg::PH_OSC, por_seq_pkg::PH_FUSE, por_seq_pkg::PH_PUMP, por_seq_pkg::PH_BANK: begin
               if (cnt_q == phase_len(phase_q)) begin // see R1
                  cnt_q <= '0;
                  case (phase_q)
                     por_seq_pkg::PH_OSC: phase_q <= por_seq_pkg::PH_FUSE;
                     por_seq_pkg::PH_FUSE: phase_q <= por_seq_pkg::PH_PUMP;
                     por_seq_pkg::PH_PUMP: phase_q <= por_seq_pkg::PH_BANK;
                     default: phase_q <= por_seq_pkg::PH_RUN;
                  endcase
               end else begin
                  cnt_q <= cnt_q + por_seq_pkg::CNT_W'(1);
               end
            end
            default: begin
               phase_q <= por_seq_pkg::PH_RUN;
            end
         endcase
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign o_por_n = por_n_q;
   assign o_phase = phase_q;
   // gated by the internal reset too, so a new reset holds the cpu in the cycle before the phase drops
   assign o_cpu_reset_n = por_n_q && (phase_q == por_seq_pkg::PH_RUN); // see R2, see R12
   assign o_boot_addr = por_seq_pkg::BOOT_ADDR; // see R2
   assign o_warm_req = !warm_pin_f;
   // drive low during any reset condition; only low is ever driven
   assign o_warm_reset_n = 1'b0;
   assign o_warm_reset_n_oe = !o_cpu_reset_n; // see R11
endmodule

// File: testbench/por_seq_chk.sv
// port assertions for the power-on reset sequencer
module por_seq_chk (
   // watched ports
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_low_power_mode,
   input wire por_seq_pkg::supply_flags_t i_supply_flags,
   input wire logic o_warm_reset_n,
   input wire logic o_warm_reset_n_oe,
   input wire por_seq_pkg::power_status_t o_status,
   input wire logic o_por_n,
   input wire logic o_cpu_reset_n,
   input wire logic [31:0] o_boot_addr,
   input wire por_seq_pkg::phase_t o_phase
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   property p_run; o_cpu_reset_n |-> o_por_n && o_phase == por_seq_pkg::PH_RUN; endproperty
   a_run: assert property (p_run) else $error("cpu released outside run");
   property p_boot; $rose(o_cpu_reset_n) |-> $past(o_phase) == por_seq_pkg::PH_BANK && o_boot_addr == 32'h0; endproperty
   a_boot: assert property (p_boot) else $error("cpu release not after bank phase");
   // open drain: data stays low, only the enable moves
   property p_oe; o_warm_reset_n_oe == !o_cpu_reset_n && !o_warm_reset_n; endproperty
   a_oe: assert property (p_oe) else $error("warm pin drive wrong");
   // the raw flag must act in the same cycle, no filter delay
   property p_hiz; !i_low_power_mode && (i_supply_flags.core_low || i_supply_flags.core_high)
      |-> o_status.outputs_hiz; endproperty
   a_hiz: assert property (p_hiz) else $error("outputs not released");
   property p_lpm; i_low_power_mode |-> !o_status.outputs_hiz; endproperty
   a_lpm: assert property (p_lpm) else $error("monitor active in low power");
   property p_iso; !(o_status.core_power_good && o_status.io_power_good)
      |-> o_status.core_isolate && o_status.io_isolate; endproperty
   a_iso: assert property (p_iso) else $error("isolation missing");
   property p_drop; !o_por_n |=> o_phase == por_seq_pkg::PH_RESET && !o_cpu_reset_n; endproperty
   a_drop: assert property (p_drop) else $error("sequence not restarted");
   property p_start; $rose(o_por_n) |=> o_phase == por_seq_pkg::PH_OSC; endproperty
   a_start: assert property (p_start) else $error("first phase not entered");
   c_run: cover property ($rose(o_cpu_reset_n));
   c_abort: cover property (!o_por_n && o_phase != por_seq_pkg::PH_RESET);
   c_hiz: cover property ($rose(o_status.outputs_hiz));
endmodule
bind supply_monitor_por_sequencer por_seq_chk chk (.i_clk, .i_arst_n, .i_low_power_mode, .i_supply_flags,
   .o_warm_reset_n, .o_warm_reset_n_oe, .o_status, .o_por_n, .o_cpu_reset_n, .o_boot_addr, .o_phase);

// File: testbench/supervisor_model.sv
// external supply supervisor driving the power-on reset pin
module supervisor_model (
   // clock and supply state
   input wire logic i_clk,
   input wire logic i_supply_bad,
   // power-on reset pin
   output logic o_power_on_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drop = 1'b0;
   assign o_power_on_reset_n = !(i_supply_bad || drop);
   task automatic pulse(input int n);
      @(negedge i_clk);
      drop = 1'b1;
      repeat (n) @(negedge i_clk);
      drop = 1'b0;
   endtask
endmodule

// File: testbench/supply_monitor_por_sequencer_tb.sv
// self-checking bench for the supply monitor and reset sequencer
`define CHK(a, b) check_eq(32'(a), 32'(b))
module supply_monitor_por_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // one cycle from the internal reset rising to the first phase, then the four phases
   localparam int SEQ = 1 + por_seq_pkg::OSC_START_CYC + por_seq_pkg::FUSE_LOAD_CYC + por_seq_pkg::PUMP_UP_CYC
      + por_seq_pkg::BANK_UP_CYC;
   logic i_clk, i_arst_n, sup_bad, ext_n, i_low_power_mode;
   logic o_warm_reset_n, o_warm_reset_n_oe, o_por_n, o_warm_req, o_cpu_reset_n;
   logic [31:0] o_boot_addr;
   wire logic pin_n;
   por_seq_pkg::supply_flags_t i_supply_flags;
   por_seq_pkg::power_status_t o_status;
   por_seq_pkg::phase_t o_phase;
   int n_mismatch = 0, compares = 0, cyc = 0, rise = 0, ph_at = 0, exp_q[$];
   wire logic warm_pin = ext_n && !(o_warm_reset_n_oe && !o_warm_reset_n);
   supervisor_model sup (.i_clk, .i_supply_bad(sup_bad), .o_power_on_reset_n(pin_n));
   supply_monitor_por_sequencer dut (
      .i_clk, .i_arst_n, .i_power_on_reset_n(pin_n), .i_supply_flags, .i_low_power_mode,
      .i_warm_reset_n(warm_pin), .o_warm_reset_n, .o_warm_reset_n_oe, .o_status, .o_por_n,
      .o_warm_req, .o_cpu_reset_n, .o_boot_addr, .o_phase);
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = !i_clk;
   end
   initial begin
      #400us;
      n_mismatch++;
      print_verdict();
   end
   always @(posedge i_clk) cyc++;
   always @(posedge o_por_n) rise = cyc;
   // forward steps happen only when a phase ran to its end, so each length is checked alone
   always @(o_phase) begin
      case (o_phase)
         por_seq_pkg::PH_FUSE: `CHK(cyc - ph_at, por_seq_pkg::OSC_START_CYC);
         por_seq_pkg::PH_PUMP: `CHK(cyc - ph_at, por_seq_pkg::FUSE_LOAD_CYC);
         por_seq_pkg::PH_BANK: `CHK(cyc - ph_at, por_seq_pkg::PUMP_UP_CYC);
         por_seq_pkg::PH_RUN: `CHK(cyc - ph_at, por_seq_pkg::BANK_UP_CYC);
         default: ;
      endcase
      ph_at = cyc;
   end
   always @(posedge o_cpu_reset_n) begin
      `CHK(exp_q.size() > 0, 1);
      if (exp_q.size() > 0) `CHK(cyc - rise, exp_q.pop_front());
   end
   task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic boot();
      exp_q.push_back(SEQ);
      for (int i = 0; i < 5000 && o_cpu_reset_n !== 1'b1; i++) @(negedge i_clk);
      `CHK(o_boot_addr, 0);
      `CHK(o_warm_reset_n_oe, 0);
   endtask
   initial begin
      i_arst_n = 1'b0;
      sup_bad = 1'b1;
      ext_n = 1'b1;
      i_low_power_mode = 1'b0;
      i_supply_flags = '0;
      void'($urandom(32'hD165C48F));
      cycles(20);
      i_arst_n = 1'b1;
      cycles(10);
      sup_bad = 1'b0;
      boot();
      repeat (3) begin
         sup.pulse($urandom_range(50, 5));
         cycles(80);
         `CHK(o_por_n, 1);
      end
      sup.pulse(250);
      `CHK(o_por_n, 0);
      sup.pulse(100);
      cycles(80);
      sup.pulse(100);
      boot();
      for (int f = 0; f < 3; f++) begin
         i_supply_flags = 3'b100 >> f;
         #1 `CHK(o_status.outputs_hiz, f < 2);
         cycles(50);
         `CHK(o_por_n, 0);
         `CHK(o_cpu_reset_n, 0);
         `CHK(o_warm_reset_n_oe, 1);
         `CHK({o_status.core_power_good, o_status.io_power_good}, {f != 0, f != 2});
         `CHK(o_status.core_isolate && o_status.io_isolate, f != 1);
         i_supply_flags = '0;
         boot();
      end
      i_low_power_mode = 1'b1;
      i_supply_flags = 3'b111;
      cycles(50);
      `CHK({o_por_n, o_status.outputs_hiz}, 2'b10);
      i_supply_flags = '0;
      cycles(50);
      i_low_power_mode = 1'b0;
      ext_n = 1'b0;
      cycles(80);
      `CHK(o_warm_req, 1);
      ext_n = 1'b1;
      cycles(80);
      `CHK(o_warm_req, 0);
      print_verdict();
   end
endmodule
